// File: core/asf_set_features.sv
// task-file decode and feature-configuration command interpreter
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - level bit 8 is max when enabled
// - bit 5 reports enhanced erase support
// - bit 4 expiry; unlock and erase abort
// - bits 3,2,1 frozen, locked, enabled
// - capability bit shows security support
// - advanced timing word reads 0492H
// - bits 2-0 supported advanced PIO mode
// - bits 5-3 supported advanced DMA mode
// - bits 8-6 selected advanced PIO mode
// - bits 11-9 selected DMA; 15-12 reserved
// - opcode EFH, feature code and config value
// - 01H/81H switch 8-bit transfers
// - 02H/82H write cache; flush on disable
// - 03H sets transfer type and mode
// - transfer type encodings, others reserved
// - one PIO mode always; only via command
// - 09H/89H switch extended power
// - 55H/AAH look-ahead, off by default
// - 66H/CCH control defaults at soft reset
// - 69H, 96H, 97H accepted as no-ops
module asf_set_features (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic soft_reset_i,
    input wire logic tf_wr_i,
    input wire logic [2:0] tf_addr_i,
    input wire logic [7:0] tf_wdata_i,
    input wire logic flush_done_i,
    input wire logic data_reg_access_i,
    input wire logic sec_supported_i,
    input wire logic sec_enabled_i,
    input wire logic sec_level_max_i,
    input wire logic sec_enh_erase_i,
    input wire logic sec_expired_i,
    input wire logic sec_frozen_i,
    input wire logic sec_locked_i,
    output logic busy_o,
    output logic cmd_done_o,
    output logic cmd_abort_o,
    output logic flush_req_o,
    output logic mode_8bit_o,
    output logic cs16_n_o,
    output logic wcache_en_o,
    output logic xpwr_en_o,
    output logic lookahead_en_o,
    output logic keep_settings_o,
    output logic [2:0] pio_mode_o,
    output logic pio_iordy_off_o,
    output logic mwdma_en_o,
    output logic [2:0] mwdma_mode_o,
    output logic udma_en_o,
    output logic [2:0] udma_mode_o,
    output logic sec_cmd_blocked_o,
    output logic [15:0] sec_word_o,
    output logic [15:0] adv_word_o
);
    asf_pkg::asf_state_t state_reg;
    asf_pkg::asf_state_t state_next;
    logic [7:0] feature_code_reg;
    logic [7:0] sector_count_config_reg;

    // task-file captures
    wire wr_feature = tf_wr_i && (tf_addr_i == asf_pkg::FEATURE_OFFSET);
    wire wr_seccnt = tf_wr_i && (tf_addr_i == asf_pkg::SECCNT_OFFSET);
    wire wr_command = tf_wr_i && (tf_addr_i == asf_pkg::COMMAND_OFFSET);
    wire start_cmd = wr_command && (tf_wdata_i == asf_pkg::CMD_SET_FEATURES)
                     && (state_reg == asf_pkg::ASF_IDLE);

    wire [4:0] xfer_type = sector_count_config_reg[7:3];
    wire [2:0] xfer_mode = sector_count_config_reg[2:0];

    // transfer-mode validation
    wire xm_pio_def = (xfer_type == asf_pkg::XT_PIO_DEFAULT)
                      && (xfer_mode == asf_pkg::XM_PIO_DEFAULT);
    wire xm_pio_nordy = (xfer_type == asf_pkg::XT_PIO_DEFAULT)
                        && (xfer_mode == asf_pkg::XM_PIO_NO_READY);
    wire xm_pio_flow = (xfer_type == asf_pkg::XT_PIO_FLOW)
                       && (xfer_mode <= asf_pkg::PIO_MAX_MODE);
    wire xm_mwdma = (xfer_type == asf_pkg::XT_MWDMA)
                    && (xfer_mode <= asf_pkg::MWDMA_MAX_MODE);
    wire xm_udma = (xfer_type == asf_pkg::XT_UDMA)
                   && (xfer_mode <= asf_pkg::UDMA_MAX_MODE);
    wire xm_valid = xm_pio_def | xm_pio_nordy | xm_pio_flow | xm_mwdma | xm_udma;

    // feature-code decode
    wire fc_8on = (feature_code_reg == asf_pkg::FC_8BIT_ON);
    wire fc_8off = (feature_code_reg == asf_pkg::FC_8BIT_OFF);
    wire fc_won = (feature_code_reg == asf_pkg::FC_WCACHE_ON);
    wire fc_woff = (feature_code_reg == asf_pkg::FC_WCACHE_OFF);
    wire fc_xm = (feature_code_reg == asf_pkg::FC_XFER_MODE);
    wire fc_pon = (feature_code_reg == asf_pkg::FC_XPWR_ON);
    wire fc_poff = (feature_code_reg == asf_pkg::FC_XPWR_OFF);
    wire fc_laoff = (feature_code_reg == asf_pkg::FC_LOOKAHEAD_OFF);
    wire fc_laon = (feature_code_reg == asf_pkg::FC_LOOKAHEAD_ON);
    wire fc_keep = (feature_code_reg == asf_pkg::FC_KEEP_SETTINGS);
    wire fc_rest = (feature_code_reg == asf_pkg::FC_RESTORE_DEFAULTS);
    wire fc_nop = (feature_code_reg == asf_pkg::FC_NOP_A)
                  || (feature_code_reg == asf_pkg::FC_NOP_B)
                  || (feature_code_reg == asf_pkg::FC_LEGACY);
    wire fc_known = fc_8on | fc_8off | fc_won | fc_woff | fc_pon | fc_poff | fc_laoff
                    | fc_laon | fc_keep | fc_rest | fc_nop | (fc_xm & xm_valid);
    // settings only move on a good command; bad ones leave them alone
    wire apply = start_cmd && fc_known;
    wire reject = start_cmd && !fc_known;

    // soft reset restores defaults unless the host asked to keep them
    wire restore = soft_reset_i && !keep_settings_o;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            asf_pkg::ASF_IDLE: begin
                if (apply && fc_woff && wcache_en_o) begin
                    state_next = asf_pkg::ASF_FLUSH;
                end else if (start_cmd) begin
                    state_next = asf_pkg::ASF_DONE;
                end
            end
            asf_pkg::ASF_FLUSH: begin
                // completion is held back until the cache is on media
                if (flush_done_i) begin
                    state_next = asf_pkg::ASF_DONE;
                end
            end
            asf_pkg::ASF_DONE: state_next = asf_pkg::ASF_IDLE;
            default: state_next = asf_pkg::ASF_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            feature_code_reg <= 8'h00;
            sector_count_config_reg <= 8'h00;
        end else if (clk_en_i) begin
            if (wr_feature) begin
                feature_code_reg <= tf_wdata_i;
            end
            if (wr_seccnt) begin
                sector_count_config_reg <= tf_wdata_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= asf_pkg::ASF_IDLE;
            busy_o <= 1'b0;
            cmd_done_o <= 1'b0;
            cmd_abort_o <= 1'b0;
            flush_req_o <= 1'b0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            busy_o <= (state_next != asf_pkg::ASF_IDLE);
            cmd_done_o <= (state_next == asf_pkg::ASF_DONE);
            flush_req_o <= (state_next == asf_pkg::ASF_FLUSH);
            if (reject) begin
                cmd_abort_o <= 1'b1;
            end else if (start_cmd) begin
                cmd_abort_o <= 1'b0;
            end
        end
    end

    // boolean feature settings
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || (clk_en_i && restore)) begin
            mode_8bit_o <= asf_pkg::RST_8BIT;
            wcache_en_o <= asf_pkg::RST_WCACHE;
            xpwr_en_o <= asf_pkg::RST_XPWR;
            lookahead_en_o <= asf_pkg::RST_LOOKAHEAD;
        end else if (clk_en_i && apply) begin
            if (fc_8on || fc_8off) begin
                mode_8bit_o <= fc_8on;
            end
            if (fc_won || fc_woff) begin
                wcache_en_o <= fc_won;
            end
            if (fc_pon || fc_poff) begin
                xpwr_en_o <= fc_pon;
            end
            if (fc_laon || fc_laoff) begin
                lookahead_en_o <= fc_laon;
            end
        end
    end

    // the keep-settings choice itself survives soft reset
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            keep_settings_o <= asf_pkg::RST_KEEP;
        end else if (clk_en_i && apply && (fc_keep || fc_rest)) begin
            keep_settings_o <= fc_keep;
        end
    end

    // transfer modes: a PIO mode is always held, DMA selections are exclusive
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || (clk_en_i && restore)) begin
            pio_mode_o <= asf_pkg::RST_PIO_MODE;
            pio_iordy_off_o <= asf_pkg::RST_PIO_IORDY_OFF;
            mwdma_en_o <= 1'b0;
            mwdma_mode_o <= 3'h0;
            udma_en_o <= 1'b0;
            udma_mode_o <= 3'h0;
        end else if (clk_en_i && apply && fc_xm) begin
            if (xm_pio_def || xm_pio_nordy) begin
                pio_mode_o <= asf_pkg::RST_PIO_MODE;
                pio_iordy_off_o <= xm_pio_nordy;
            end
            if (xm_pio_flow) begin
                pio_mode_o <= xfer_mode;
                pio_iordy_off_o <= 1'b0;
            end
            if (xm_mwdma) begin
                mwdma_en_o <= 1'b1;
                mwdma_mode_o <= xfer_mode;
                udma_en_o <= 1'b0;
            end
            if (xm_udma) begin
                udma_en_o <= 1'b1;
                udma_mode_o <= xfer_mode;
                mwdma_en_o <= 1'b0;
            end
        end
    end

    // 16-bit indication suppressed on data accesses in 8-bit mode
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cs16_n_o <= 1'b1;
            sec_cmd_blocked_o <= 1'b0;
        end else if (clk_en_i) begin
            cs16_n_o <= !(data_reg_access_i && !mode_8bit_o);
            // only power-on or hard reset clears expiry, so no soft-reset path
            sec_cmd_blocked_o <= sec_expired_i;
        end
    end

    asf_idword u_idword (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .sec_supported_i(sec_supported_i),
        .sec_enabled_i(sec_enabled_i),
        .sec_level_max_i(sec_level_max_i),
        .sec_enh_erase_i(sec_enh_erase_i),
        .sec_expired_i(sec_expired_i),
        .sec_frozen_i(sec_frozen_i),
        .sec_locked_i(sec_locked_i),
        .sec_word_o(sec_word_o),
        .adv_word_o(adv_word_o)
    );
endmodule : asf_set_features
`default_nettype wire

// File: core/asf_pkg.sv
// constants for the feature-configuration command block
package asf_pkg;
    localparam logic [2:0] FEATURE_OFFSET = 3'h1;
    localparam logic [2:0] SECCNT_OFFSET = 3'h2;
    localparam logic [2:0] SECNUM_OFFSET = 3'h3;
    localparam logic [2:0] CYLLO_OFFSET = 3'h4;
    localparam logic [2:0] CYLHI_OFFSET = 3'h5;
    localparam logic [2:0] DRVHD_OFFSET = 3'h6;
    localparam logic [2:0] COMMAND_OFFSET = 3'h7;

    localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;

    localparam logic [7:0] FC_8BIT_ON = 8'h01;
    localparam logic [7:0] FC_WCACHE_ON = 8'h02;
    localparam logic [7:0] FC_XFER_MODE = 8'h03;
    localparam logic [7:0] FC_XPWR_ON = 8'h09;
    localparam logic [7:0] FC_LOOKAHEAD_OFF = 8'h55;
    localparam logic [7:0] FC_KEEP_SETTINGS = 8'h66;
    localparam logic [7:0] FC_NOP_A = 8'h69;
    localparam logic [7:0] FC_8BIT_OFF = 8'h81;
    localparam logic [7:0] FC_WCACHE_OFF = 8'h82;
    localparam logic [7:0] FC_XPWR_OFF = 8'h89;
    localparam logic [7:0] FC_NOP_B = 8'h96;
    localparam logic [7:0] FC_LEGACY = 8'h97;
    localparam logic [7:0] FC_LOOKAHEAD_ON = 8'hAA;
    localparam logic [7:0] FC_RESTORE_DEFAULTS = 8'hCC;

    localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
    localparam logic [4:0] XT_PIO_FLOW = 5'h01;
    localparam logic [4:0] XT_MWDMA = 5'h04;
    localparam logic [4:0] XT_UDMA = 5'h08;
    localparam logic [2:0] XM_PIO_DEFAULT = 3'h0;
    localparam logic [2:0] XM_PIO_NO_READY = 3'h1;

    localparam int SEC_LEVEL_BIT = 8;
    localparam int SEC_ENH_ERASE_BIT = 5;
    localparam int SEC_EXPIRE_BIT = 4;
    localparam int SEC_FROZEN_BIT = 3;
    localparam int SEC_LOCKED_BIT = 2;
    localparam int SEC_ENABLED_BIT = 1;
    localparam int SEC_CAPABLE_BIT = 0;

    localparam logic [15:0] ADV_TIMING_WORD = 16'h0492;
    localparam int ADV_PIO_SUP_LSB = 0;
    localparam int ADV_DMA_SUP_LSB = 3;
    localparam int ADV_PIO_SEL_LSB = 6;
    localparam int ADV_DMA_SEL_LSB = 9;

    localparam logic [2:0] ADV_NONE = 3'h0;
    localparam logic [2:0] ADV_LOW = 3'h1;
    localparam logic [2:0] ADV_HIGH = 3'h2;

    localparam logic [2:0] PIO_MAX_MODE = 3'h6;
    localparam logic [2:0] MWDMA_MAX_MODE = 3'h4;
    localparam logic [2:0] UDMA_MAX_MODE = 3'h4;

    // power-on default settings
    localparam logic RST_8BIT = 1'b0;
    localparam logic RST_WCACHE = 1'b0;
    localparam logic RST_XPWR = 1'b0;
    localparam logic RST_LOOKAHEAD = 1'b0;
    localparam logic RST_KEEP = 1'b0;
    localparam logic [2:0] RST_PIO_MODE = 3'h0;
    localparam logic RST_PIO_IORDY_OFF = 1'b0;

    localparam int FLUSH_WAIT_CYCLES = 1;

    typedef enum logic [1:0] {
        ASF_IDLE,
        ASF_FLUSH,
        ASF_DONE
    } asf_state_t;
endpackage : asf_pkg

// File: core/asf_idword.sv
// formatter for the security-status and advanced-timing identify words
`timescale 1ns/1ps
`default_nettype none
module asf_idword (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic sec_supported_i,
    input wire logic sec_enabled_i,
    input wire logic sec_level_max_i,
    input wire logic sec_enh_erase_i,
    input wire logic sec_expired_i,
    input wire logic sec_frozen_i,
    input wire logic sec_locked_i,
    output logic [15:0] sec_word_o,
    output logic [15:0] adv_word_o
);
    logic [15:0] sec_next;

    always_comb begin
        sec_next = 16'h0000;
        // level only means something while enabled
        sec_next[asf_pkg::SEC_LEVEL_BIT] = sec_enabled_i & sec_level_max_i;
        sec_next[asf_pkg::SEC_ENH_ERASE_BIT] = sec_enh_erase_i;
        sec_next[asf_pkg::SEC_EXPIRE_BIT] = sec_expired_i;
        sec_next[asf_pkg::SEC_FROZEN_BIT] = sec_frozen_i;
        sec_next[asf_pkg::SEC_LOCKED_BIT] = sec_locked_i;
        sec_next[asf_pkg::SEC_ENABLED_BIT] = sec_enabled_i;
        sec_next[asf_pkg::SEC_CAPABLE_BIT] = sec_supported_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sec_word_o <= 16'h0000;
            adv_word_o <= 16'h0000;
        end else if (clk_en_i) begin
            sec_word_o <= sec_next;
            // fixed value regardless of selection: the word reports 0492H
            adv_word_o <= asf_pkg::ADV_TIMING_WORD;
        end
    end
endmodule : asf_idword
`default_nettype wire

// File: verif/asf_set_features_asserts.sv
// assertion checker for the feature-configuration block
`timescale 1ns/1ps
`default_nettype none
module asf_set_features_asserts (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic tf_wr_i,
    input wire logic [2:0] tf_addr_i,
    input wire logic [7:0] tf_wdata_i,
    input wire logic sec_enabled_i,
    input wire logic sec_level_max_i,
    input wire logic sec_expired_i,
    input wire logic sec_frozen_i,
    input wire logic sec_locked_i,
    input wire logic busy_o,
    input wire logic cmd_done_o,
    input wire logic flush_req_o,
    input wire logic mode_8bit_o,
    input wire logic cs16_n_o,
    input wire logic sec_cmd_blocked_o,
    input wire logic [15:0] sec_word_o,
    input wire logic [15:0] adv_word_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_adv_fixed: assert property (
        $past(!reset_i && clk_en_i) |-> adv_word_o == 16'h0492)
        else $error("advanced timing word wrong");
    chk_sec_flags: assert property (
        $past(!reset_i && clk_en_i) |-> sec_word_o[4:1] ==
        $past({sec_expired_i, sec_frozen_i, sec_locked_i, sec_enabled_i}))
        else $error("security flag bits wrong");
    chk_sec_level: assert property (
        $past(!reset_i && clk_en_i) |->
        sec_word_o[8] == $past(sec_level_max_i && sec_enabled_i))
        else $error("security level bit wrong");
    chk_expire_block: assert property (
        $past(!reset_i && clk_en_i) |-> sec_cmd_blocked_o == $past(sec_expired_i))
        else $error("expiry block wrong");
    chk_cmd_start: assert property (
        clk_en_i && tf_wr_i && tf_addr_i == 3'h7 && tf_wdata_i == 8'hEF && !busy_o
        |=> busy_o)
        else $error("command not started");
    chk_done_pulse: assert property (
        cmd_done_o && clk_en_i |=> !cmd_done_o)
        else $error("done longer than one cycle");
    chk_flush_wait: assert property (
        flush_req_o |-> busy_o && !cmd_done_o)
        else $error("completion before flush");
    chk_cs16_8bit: assert property (
        $past(mode_8bit_o && clk_en_i) && mode_8bit_o |-> cs16_n_o)
        else $error("16-bit indication in 8-bit mode");
endmodule : asf_set_features_asserts

bind asf_set_features asf_set_features_asserts u_asf_set_features_asserts (
    .ref_clk_i, .reset_i, .clk_en_i, .tf_wr_i, .tf_addr_i, .tf_wdata_i,
    .sec_enabled_i, .sec_level_max_i, .sec_expired_i, .sec_frozen_i, .sec_locked_i,
    .busy_o, .cmd_done_o, .flush_req_o, .mode_8bit_o, .cs16_n_o,
    .sec_cmd_blocked_o, .sec_word_o, .adv_word_o);
`default_nettype wire

// File: verif/asf_host_model.sv
// host-side model that writes the task file
`timescale 1ns/1ps
`default_nettype none
module asf_host_model (
    input wire logic ref_clk_i,
    output logic tf_wr_o,
    output logic [2:0] tf_addr_o,
    output logic [7:0] tf_wdata_o
);
    initial begin
        tf_wr_o = 1'b0;
        tf_addr_o = 3'h0;
        tf_wdata_o = 8'h00;
    end

    // lines scrambled after the strobe so stale data cannot pass
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        tf_wr_o = 1'b1;
        tf_addr_o = a;
        tf_wdata_o = d;
        @(posedge ref_clk_i);
        #1;
        tf_wr_o = 1'b0;
        tf_addr_o = ~a;
        tf_wdata_o = ~d;
    endtask : wr

    task automatic issue(input logic [7:0] fc, input logic [7:0] cnt);
        wr(3'h1, fc);
        wr(3'h2, cnt);
        wr(3'h7, 8'hEF);
    endtask : issue
endmodule : asf_host_model
`default_nettype wire

// File: verif/asf_set_features_bench.sv
// testbench for the feature-configuration block
`timescale 1ns/1ps
`default_nettype none
module asf_set_features_bench;
    logic ref_clk;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic soft_reset = 1'b0;
    logic flush_done = 1'b0;
    logic dra = 1'b0;
    logic [6:0] sec = 7'h00;
    logic [2:0] fl_cnt = 3'h0;
    logic tf_wr, busy, done, abort, flush_req, m8, cs16_n, wc, xp, la, keep;
    logic iordy, mw_en, u_en, blocked;
    logic [2:0] tf_addr, pio, mw_mode, u_mode;
    logic [7:0] tf_wdata;
    logic [15:0] sec_w, adv_w;
    int checked = 0;
    int miscompares = 0;
    int k;
    wire logic [15:0] setv = {11'h000, m8, wc, xp, la, keep};
    wire logic [15:0] xfer = {4'h0, pio, iordy, mw_en, mw_mode, u_en, u_mode};
    logic [7:0] fcs [13] = '{8'h01, 8'h02, 8'h09, 8'hAA, 8'h66, 8'h69, 8'h96,
        8'h97, 8'h81, 8'h82, 8'h89, 8'h55, 8'hCC};
    logic [4:0] exs [13] = '{5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F, 5'h1F, 5'h1F,
        5'h1F, 5'h0F, 5'h07, 5'h03, 5'h01, 5'h00};
    logic [7:0] xcnt [10] = '{8'h0E, 8'h24, 8'h44, 8'h02, 8'h10, 8'h25, 8'h0F,
        8'h45, 8'h01, 8'h00};
    logic [15:0] xexp [10] = '{16'h0C00, 16'h00C0, 16'h0C0C, 16'h0C0C, 16'h0C0C,
        16'h0C0C, 16'h0C0C, 16'h0C0C, 16'h0100, 16'h0000};
    logic [15:0] xmsk [10] = '{16'h0E00, 16'h00F8, 16'h0E8F, 16'h0E8F, 16'h0E8F,
        16'h0E8F, 16'h0E8F, 16'h0E8F, 16'h0F00, 16'h0F00};
    logic [0:9] xab = 10'b0001111100;

    asf_host_model u_asf_host_model (.ref_clk_i(ref_clk), .tf_wr_o(tf_wr),
        .tf_addr_o(tf_addr), .tf_wdata_o(tf_wdata));

    asf_set_features u_asf_set_features (.ref_clk_i(ref_clk), .reset_i(reset),
        .clk_en_i(clk_en), .soft_reset_i(soft_reset), .tf_wr_i(tf_wr),
        .tf_addr_i(tf_addr), .tf_wdata_i(tf_wdata), .flush_done_i(flush_done),
        .data_reg_access_i(dra), .sec_supported_i(sec[0]), .sec_enabled_i(sec[1]),
        .sec_level_max_i(sec[2]), .sec_enh_erase_i(sec[3]), .sec_expired_i(sec[4]),
        .sec_frozen_i(sec[5]), .sec_locked_i(sec[6]), .busy_o(busy),
        .cmd_done_o(done), .cmd_abort_o(abort), .flush_req_o(flush_req),
        .mode_8bit_o(m8), .cs16_n_o(cs16_n), .wcache_en_o(wc), .xpwr_en_o(xp),
        .lookahead_en_o(la), .keep_settings_o(keep), .pio_mode_o(pio),
        .pio_iordy_off_o(iordy), .mwdma_en_o(mw_en), .mwdma_mode_o(mw_mode),
        .udma_en_o(u_en), .udma_mode_o(u_mode), .sec_cmd_blocked_o(blocked),
        .sec_word_o(sec_w), .adv_word_o(adv_w));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // media stalls a few cycles before confirming the flush
    always @(posedge ref_clk) begin
        fl_cnt <= flush_req ? fl_cnt + 3'h1 : 3'h0;
        flush_done <= #1 (fl_cnt == 3'h3);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] fc, input logic [7:0] cnt, input logic ab);
        int i;
        u_asf_host_model.issue(fc, cnt);
        for (i = 0; i < 20 && done !== 1'b1; i++) tick(1);
        chk("cmd_done", 16'h0001, {15'h0000, done});
        chk("cmd_abort", {15'h0000, ab}, {15'h0000, abort});
        tick(1);
    endtask : cmd

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    initial begin
        #40000;
        miscompares++;
        finish_test();
    end

    initial begin
        tick(3);
        reset = 1'b0;
        tick(1);
        chk("settings", 16'h0000, setv);
        chk("cs16_n", 16'h0001, {15'h0000, cs16_n});
        chk("adv_word", 16'h0492, adv_w);
        for (k = 0; k < 13; k++) begin
            cmd(fcs[k], 8'h00, 1'b0);
            chk("settings", {11'h000, exs[k]}, setv);
        end
        cmd(8'h04, 8'h00, 1'b1);
        cmd(8'hFF, 8'h00, 1'b1);
        cmd(8'h02, 8'h00, 1'b0);
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
        tick(1);
        chk("settings", 16'h0000, setv);
        cmd(8'h02, 8'h00, 1'b0);
        cmd(8'h66, 8'h00, 1'b0);
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
        tick(1);
        chk("settings", 16'h0009, setv);
        // cache is on, so disabling it must wait for the media flush
        u_asf_host_model.issue(8'h82, 8'h00);
        chk("flush_req", 16'h0001, {15'h0000, flush_req});
        chk("busy", 16'h0001, {15'h0000, busy});
        chk("cmd_done", 16'h0000, {15'h0000, done});
        for (k = 0; k < 20 && done !== 1'b1; k++) tick(1);
        chk("cmd_done", 16'h0001, {15'h0000, done});
        chk("flush_req", 16'h0000, {15'h0000, flush_req});
        chk("settings", 16'h0001, setv);
        tick(1);
        u_asf_host_model.wr(3'h7, 8'hE3);
        tick(2);
        chk("busy", 16'h0000, {15'h0000, busy});
        dra = 1'b1;
        tick(2);
        chk("cs16_n", 16'h0000, {15'h0000, cs16_n});
        cmd(8'h01, 8'h00, 1'b0);
        chk("cs16_n", 16'h0001, {15'h0000, cs16_n});
        dra = 1'b0;
        for (k = 0; k < 10; k++) begin
            cmd(8'h03, xcnt[k], xab[k]);
            chk("xfer", xexp[k], xfer & xmsk[k]);
        end
        sec = 7'h7F;
        tick(2);
        chk("sec_word", 16'h013F, sec_w);
        chk("blocked", 16'h0001, {15'h0000, blocked});
        // clock enable low must freeze the word
        clk_en = 1'b0;
        sec = 7'h7D;
        tick(2);
        chk("sec_frozen", 16'h013F, sec_w);
        clk_en = 1'b1;
        tick(2);
        chk("sec_word", 16'h003D, sec_w);
        sec = 7'h00;
        tick(2);
        chk("sec_word", 16'h0000, sec_w);
        chk("adv_word", 16'h0492, adv_w);
        // hard reset mid-run also clears the keep choice
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        chk("adv_in_reset", 16'h0000, adv_w);
        tick(1);
        chk("adv_word", 16'h0492, adv_w);
        chk("settings", 16'h0000, setv);
        finish_test();
    end
endmodule : asf_set_features_bench
`default_nettype wire
